// >>> hdl/ssea_aggregator.sv
// Management interrupt status/enable aggregator with an AHB-Lite register slave.
// Assumes level and event sources come from logic on clk; only the infrared receive pins are asynchronous.
// Behaviour
// - Mouse, keyboard, port-12 status follow their sources; register access never clears them.
// - Infrared status sets on any transition of the selected receive input that holds for two samples.
// - Reading status register two clears the infrared transition status.
// - Status three latches pin 20-22, 24-26, 60 events; bit 3 reserved.
// - Status four latches pin 30-33, 41-43 and 61 events.
// - Status five latches pins 54-57 and fan speed events; bits 4,5 reserved.
// - Status three to five bits clear when software writes one to them.
// - Offset 15 reads zero and ignores writes.
// - All status and enable registers reset to zero.
// - Enable one gates parallel, both UARTs, floppy, MIDI, watchdog onto group.
// - Enable two bits 0,1,2,4 gate mouse, keyboard, infrared, port-12 onto group.
// - Enable two bit 5 routes the group interrupt to the wake logic.
// - Enable two bit 6 routes the group interrupt onto serial interrupt stream.
// - Enable two bit 7 routes the group interrupt to the active-low pin.
// - Enable three gates status three bit for bit onto the group.
// - Status one holds parallel, UARTs, floppy, MIDI, watchdog, cleared at source.
// - Enable four gates status four bit for bit onto the group.
// - Enable five gates status five bit for bit onto the group.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module ssea_aggregator (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire ssea_pkg::ssea_lvl1_t lvl1_src,
   input wire ssea_pkg::ssea_lvl2_t lvl2_src,
   input wire ssea_pkg::ssea_events_t gpio_events,
   input wire logic infrared_receive_primary,
   input wire logic infrared_receive_secondary,
   input wire logic infrared_select_secondary,
   output logic group_mgmt_irq_n,
   output logic mgmt_irq_pin_n,
   output ssea_pkg::ssea_route_t group_route
);
   import ssea_pkg::*;

   // Only whole-word transfers reach the registers; other sizes pass with no effect
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   // Status one bit positions
   localparam int STS1_PARALLEL = 1;
   localparam int STS1_UART_B = 2;
   localparam int STS1_UART_A = 3;
   localparam int STS1_FLOPPY = 4;
   localparam int STS1_MIDI = 5;
   localparam int STS1_WATCHDOG = 7;

   localparam logic [REG_W-1:0] W1C_MASK [NUM_W1C] = '{MASK_STS3, MASK_STS4, MASK_STS5};
   localparam logic [REG_W-1:0] EN_MASK [NUM_EN] = '{MASK_EN1, MASK_EN2_ALL, MASK_EN3, MASK_EN4, MASK_EN5};
   localparam logic [IDX_W-1:0] W1C_IDX [NUM_W1C] = '{IDX_STS3, IDX_STS4, IDX_STS5};
   localparam logic [IDX_W-1:0] EN_IDX [NUM_EN] = '{IDX_EN1, IDX_EN2, IDX_EN3, IDX_EN4, IDX_EN5};

   // Bus address phase capture
   logic wr_pend_r;
   logic [IDX_W-1:0] wr_idx_r;
   logic [IDX_W-1:0] rd_idx_r;
   logic addr_ok;
   logic addr_take;
   logic [IDX_W-1:0] addr_idx;
   ssea_rd_state_t rd_state_r;
   ssea_rd_state_t rd_state_nxt;
   logic rd_capture;

   // Register storage
   logic [REG_W-1:0] sts1_r;
   logic [REG_W-1:0] sts2_lvl_r;
   logic ir_status_r;
   logic [REG_W-1:0] w1c_r [NUM_W1C];
   logic [REG_W-1:0] en_r [NUM_EN];
   logic [REG_W-1:0] w1c_evt [NUM_W1C];
   logic [REG_W-1:0] sts1_in;
   logic [REG_W-1:0] sts2_view;
   logic [REG_W-1:0] rd_byte;
   logic [REG_W-1:0] wr_byte;
   logic wr_do;

   // Infrared receive synchroniser
   logic [2:0] ir_pri_sync_r;
   logic [2:0] ir_sec_sync_r;
   logic ir_stable_r;
   logic ir_sel_s2;
   logic ir_sel_s3;
   logic ir_edge;

   // Group interrupt
   logic group_any;

   assign addr_ok = (haddr[31:IDX_W+ADDR_LSB] == '0);
   assign addr_idx = haddr[IDX_W+ADDR_LSB-1:ADDR_LSB];
   assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
   assign wr_do = wr_pend_r && hready;
   assign wr_byte = hwdata[REG_W-1:0];

   // Reads take one wait state so that a write just before is already visible
   always_comb begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         RD_IDLE: begin
            if (addr_take && !hwrite) begin
               rd_state_nxt = RD_WAIT;
            end
         end
         RD_WAIT: begin
            rd_state_nxt = RD_DATA;
         end
         RD_DATA: begin
            if (addr_take && !hwrite) begin
               rd_state_nxt = RD_WAIT;
            end else begin
               rd_state_nxt = RD_IDLE;
            end
         end
         default: begin
            rd_state_nxt = RD_IDLE;
         end
      endcase
   end

   assign rd_capture = (rd_state_r == RD_WAIT);
   assign hreadyout = (rd_state_r != RD_WAIT);
   assign hresp = HRESP_OKAY;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_state_r <= RD_IDLE;
      end else begin
         rd_state_r <= rd_state_nxt;
      end
   end

   // An unmapped address is folded onto the reserved slot so it reads zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rd_idx_r <= '0;
      end else if (addr_take && !hwrite) begin
         rd_idx_r <= addr_ok ? addr_idx : IDX_RSVD;
      end
   end

   // A write lands at the end of its data phase, when hready is high
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_pend_r <= 1'b0;
      end else if (addr_take && hwrite) begin
         wr_pend_r <= 1'b1;
      end else if (hready) begin
         wr_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_idx_r <= '0;
      end else if (addr_take && hwrite) begin
         wr_idx_r <= addr_ok ? addr_idx : IDX_RSVD;
      end
   end

   // Status one lines its sources up at their bit positions; reserved bits stay zero
   always_comb begin
      sts1_in = ZERO_BYTE;
      sts1_in[STS1_PARALLEL] = lvl1_src.parallel_irq_status;
      sts1_in[STS1_UART_B] = lvl1_src.uart_b_irq_status;
      sts1_in[STS1_UART_A] = lvl1_src.uart_a_irq_status;
      sts1_in[STS1_FLOPPY] = lvl1_src.floppy_irq_status;
      sts1_in[STS1_MIDI] = lvl1_src.midi_irq_status;
      sts1_in[STS1_WATCHDOG] = lvl1_src.watchdog_irq_status;
   end

   // Status one and the level part of status two are live copies of their sources
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sts1_r <= REG_RESET;
      end else begin
         sts1_r <= sts1_in & MASK_STS1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sts2_lvl_r <= REG_RESET;
      end else begin
         sts2_lvl_r <= ZERO_BYTE;
         sts2_lvl_r[STS2_MOUSE] <= lvl2_src.mouse_irq_status;
         sts2_lvl_r[STS2_KEYBOARD] <= lvl2_src.keyboard_irq_status;
         sts2_lvl_r[STS2_PORT12] <= lvl2_src.port_one_bit_two_status;
      end
   end

   // Both pins pass three flops; the mux sits after them and the first flops feed only the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ir_pri_sync_r <= '0;
      end else begin
         ir_pri_sync_r <= {ir_pri_sync_r[1:0], infrared_receive_primary};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ir_sec_sync_r <= '0;
      end else begin
         ir_sec_sync_r <= {ir_sec_sync_r[1:0], infrared_receive_secondary};
      end
   end

   assign ir_sel_s2 = infrared_select_secondary ? ir_sec_sync_r[1] : ir_pri_sync_r[1];
   assign ir_sel_s3 = infrared_select_secondary ? ir_sec_sync_r[2] : ir_pri_sync_r[2];
   assign ir_edge = (ir_sel_s2 == ir_sel_s3) && (ir_sel_s3 != ir_stable_r);

   // Stable level resets to zero, so a high input after reset counts as a transition; a select change that differs counts as one too
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ir_stable_r <= 1'b0;
      end else if (ir_sel_s2 == ir_sel_s3) begin
         ir_stable_r <= ir_sel_s3;
      end
   end

   // Set wins, so an edge that lands on the clearing read is not lost
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ir_status_r <= 1'b0;
      end else if (ir_edge) begin
         ir_status_r <= 1'b1;
      end else if (rd_capture && rd_idx_r == IDX_STS2) begin
         ir_status_r <= 1'b0;
      end
   end

   always_comb begin
      sts2_view = sts2_lvl_r;
      sts2_view[STS2_INFRARED] = ir_status_r;
      sts2_view = sts2_view & MASK_STS2;
   end

   assign w1c_evt[0] = gpio_events.grp3 & MASK_STS3;
   assign w1c_evt[1] = gpio_events.grp4 & MASK_STS4;
   assign w1c_evt[2] = gpio_events.grp5 & MASK_STS5;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_W1C; gi = gi + 1) begin : g_w1c
         always_ff @(posedge clk) begin
            if (!resetn) begin
               w1c_r[gi] <= REG_RESET;
            end else if (wr_do && wr_idx_r == W1C_IDX[gi]) begin
               w1c_r[gi] <= ((w1c_r[gi] & ~wr_byte) | w1c_evt[gi]) & W1C_MASK[gi];
            end else begin
               w1c_r[gi] <= (w1c_r[gi] | w1c_evt[gi]) & W1C_MASK[gi];
            end
         end
      end
      for (gi = 0; gi < NUM_EN; gi = gi + 1) begin : g_en
         always_ff @(posedge clk) begin
            if (!resetn) begin
               en_r[gi] <= REG_RESET;
            end else if (wr_do && wr_idx_r == EN_IDX[gi]) begin
               en_r[gi] <= wr_byte & EN_MASK[gi];
            end
         end
      end
   endgenerate

   // Read mux; unmapped and reserved indices return zero
   always_comb begin
      case (rd_idx_r)
         IDX_STS1: rd_byte = sts1_r;
         IDX_STS2: rd_byte = sts2_view;
         IDX_STS3: rd_byte = w1c_r[0];
         IDX_STS4: rd_byte = w1c_r[1];
         IDX_STS5: rd_byte = w1c_r[2];
         IDX_EN1: rd_byte = en_r[0];
         IDX_EN2: rd_byte = en_r[1];
         IDX_EN3: rd_byte = en_r[2];
         IDX_EN4: rd_byte = en_r[3];
         IDX_EN5: rd_byte = en_r[4];
         default: rd_byte = ZERO_BYTE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         hrdata <= '0;
      end else if (rd_capture) begin
         hrdata <= {24'h000000, rd_byte};
      end
   end

   // Routing bits of enable two are excluded from the source gating
   assign group_any = |(sts1_r & en_r[0])
                    | |(sts2_view & en_r[1] & MASK_EN2)
                    | |(w1c_r[0] & en_r[2])
                    | |(w1c_r[1] & en_r[3])
                    | |(w1c_r[2] & en_r[4]);

   // Every interrupt output is a flop so the far side never sees a decode glitch
   always_ff @(posedge clk) begin
      if (!resetn) begin
         group_mgmt_irq_n <= 1'b1;
      end else begin
         group_mgmt_irq_n <= !group_any;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         mgmt_irq_pin_n <= 1'b1;
      end else begin
         mgmt_irq_pin_n <= !(group_any && en_r[1][EN2_ROUTE_PIN]);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         group_route.serial_irq_req <= 1'b0;
      end else begin
         group_route.serial_irq_req <= group_any && en_r[1][EN2_ROUTE_SERIAL];
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         group_route.wake_req <= 1'b0;
      end else begin
         group_route.wake_req <= group_any && en_r[1][EN2_ROUTE_WAKE];
      end
   end

endmodule : ssea_aggregator

// >>> hdl/ssea_pkg.sv
// Package for the management interrupt status/enable aggregator.
// Assumes word-wide AHB-Lite register access; each register index maps to byte address index*4.
package ssea_pkg;
   localparam int REG_W = 8;
   localparam int IDX_W = 6;
   // Register indices as printed; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STS1 = 6'h10;
   localparam logic [IDX_W-1:0] IDX_STS2 = 6'h11;
   localparam logic [IDX_W-1:0] IDX_STS3 = 6'h12;
   localparam logic [IDX_W-1:0] IDX_STS4 = 6'h13;
   localparam logic [IDX_W-1:0] IDX_STS5 = 6'h14;
   localparam logic [IDX_W-1:0] IDX_RSVD = 6'h15;
   localparam logic [IDX_W-1:0] IDX_EN1 = 6'h16;
   localparam logic [IDX_W-1:0] IDX_EN2 = 6'h17;
   localparam logic [IDX_W-1:0] IDX_EN3 = 6'h18;
   localparam logic [IDX_W-1:0] IDX_EN4 = 6'h19;
   localparam logic [IDX_W-1:0] IDX_EN5 = 6'h1a;
   localparam int ADDR_LSB = 2;
   localparam int NUM_W1C = 3;
   localparam int NUM_EN = 5;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;
   localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;
   // Implemented-bit masks; reserved positions read zero and drop writes
   localparam logic [REG_W-1:0] MASK_STS1 = 8'hbe;
   localparam logic [REG_W-1:0] MASK_STS2 = 8'h17;
   localparam logic [REG_W-1:0] MASK_STS3 = 8'hf7;
   localparam logic [REG_W-1:0] MASK_STS4 = 8'hff;
   localparam logic [REG_W-1:0] MASK_STS5 = 8'hcf;
   localparam logic [REG_W-1:0] MASK_EN1 = 8'hbe;
   localparam logic [REG_W-1:0] MASK_EN2 = 8'h17;
   localparam logic [REG_W-1:0] MASK_EN3 = 8'hf7;
   localparam logic [REG_W-1:0] MASK_EN4 = 8'hff;
   localparam logic [REG_W-1:0] MASK_EN5 = 8'hcf;
   localparam logic [REG_W-1:0] MASK_EN2_ALL = 8'hf7;
   // Status register two fields
   localparam int STS2_MOUSE = 0;
   localparam int STS2_KEYBOARD = 1;
   localparam int STS2_INFRARED = 2;
   localparam int STS2_PORT12 = 4;
   // Enable register two routing fields
   localparam int EN2_ROUTE_WAKE = 5;
   localparam int EN2_ROUTE_SERIAL = 6;
   localparam int EN2_ROUTE_PIN = 7;
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [1:0] HRESP_OKAY = 2'b00;

   // Level sources of status register one, in register bit order with the reserved bits left out
   typedef struct packed {
      logic watchdog_irq_status;
      logic midi_irq_status;
      logic floppy_irq_status;
      logic uart_a_irq_status;
      logic uart_b_irq_status;
      logic parallel_irq_status;
   } ssea_lvl1_t;

   // Level sources of status register two
   typedef struct packed {
      logic mouse_irq_status;
      logic keyboard_irq_status;
      logic port_one_bit_two_status;
   } ssea_lvl2_t;

   // One-cycle event pulses, one byte per write-one-to-clear status register
   typedef struct packed {
      logic [REG_W-1:0] grp5;
      logic [REG_W-1:0] grp4;
      logic [REG_W-1:0] grp3;
   } ssea_events_t;

   // Group interrupt routes, all registered
   typedef struct packed {
      logic wake_req;
      logic serial_irq_req;
   } ssea_route_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_WAIT = 2'b01,
      RD_DATA = 2'b11
   } ssea_rd_state_t;
endpackage : ssea_pkg

// >>> tb/ssea_aggregator_asserts.sv
// Checker for the management interrupt aggregator, bound to its top ports.
// Assumes a single slave, so hready is the slave's own hreadyout.
`timescale 1ns/1ns
module ssea_aggregator_asserts
   import ssea_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [1:0] hresp,
   input wire logic [31:0] hrdata,
   input wire logic group_mgmt_irq_n,
   input wire logic mgmt_irq_pin_n,
   input wire ssea_pkg::ssea_route_t group_route
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire logic take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == 3'b010;

   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase was stretched");
   chk_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite))
      else $error("wait state without a read");
   chk_resp_okay: assert property (hresp == HRESP_OKAY)
      else $error("response not okay");
   chk_upper_zero: assert property (hrdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   chk_pin_route: assert property (!mgmt_irq_pin_n |-> !group_mgmt_irq_n)
      else $error("pin active without group interrupt");
   chk_serial_route: assert property (group_route.serial_irq_req |-> !group_mgmt_irq_n)
      else $error("serial request without group interrupt");
   chk_wake_route: assert property (group_route.wake_req |-> !group_mgmt_irq_n)
      else $error("wake request without group interrupt");
   chk_reset_idle: assert property (disable iff (1'b0) !resetn |=>
      group_mgmt_irq_n && mgmt_irq_pin_n && group_route == '0 && hrdata == 32'h0)
      else $error("outputs not idle in reset");

   cover property (take && !hwrite);
   cover property (!mgmt_irq_pin_n);
   cover property (group_route.wake_req && group_route.serial_irq_req);
endmodule : ssea_aggregator_asserts

bind ssea_aggregator ssea_aggregator_asserts u_chk (.clk(clk), .resetn(resetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .group_mgmt_irq_n(group_mgmt_irq_n),
   .mgmt_irq_pin_n(mgmt_irq_pin_n), .group_route(group_route));

// >>> tb/ssea_aggregator_bench.sv
// Self-checking bench for the aggregator: AHB-Lite register tasks plus source stimulus.
// Assumes the host model on the routed outputs; expectations come from the register map.
`timescale 1ns/1ns
module ssea_aggregator_bench;
   import ssea_pkg::*;
   logic clk = 0;
   logic resetn = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic hready;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [31:0] hrdata;
   logic [1:0] htrans = 0;
   logic [1:0] hresp;
   logic [2:0] hsize = 3'b010;
   logic ir_a = 0;
   logic ir_b = 0;
   logic ir_sel = 0;
   logic grp_n;
   logic pin_n;
   logic [7:0] rd;
   ssea_lvl1_t lvl1 = '0;
   ssea_lvl2_t lvl2 = '0;
   ssea_events_t ev = '0;
   ssea_route_t route;
   int bad_count = 0;
   int tests_run = 0;
   int pin_falls;
   int serial_rises;
   localparam logic [7:0] EXP_EN[5] = '{8'hbe, 8'hf7, 8'hf7, 8'hff, 8'hcf};

   ssea_aggregator i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .lvl1_src(lvl1), .lvl2_src(lvl2), .gpio_events(ev),
      .infrared_receive_primary(ir_a), .infrared_receive_secondary(ir_b),
      .infrared_select_secondary(ir_sel), .group_mgmt_irq_n(grp_n), .mgmt_irq_pin_n(pin_n),
      .group_route(route));
   ssea_host_model i_host (.clk(clk), .resetn(resetn), .mgmt_irq_pin_n(pin_n), .group_route(route),
      .pin_falls(pin_falls), .serial_rises(serial_rises));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h want %h", $time, seen, exp);
      end
   endtask : chk

   // Values sampled right after an edge are still the pre-edge ones
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end
   endtask : wait_ready

   task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      wait_ready();
      rd = hrdata[7:0];
   endtask : bus

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc

   // Group outputs trail a register write by one edge
   task automatic gate(input logic [5:0] idx, input logic [7:0] v, input logic exp_n);
      bus(1'b1, idx, v);
      cyc(3);
      chk({7'h0, grp_n}, {7'h0, exp_n});
   endtask : gate

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 16; i <= 27; i++) begin
         bus(1'b0, i[5:0], 8'h00);
         chk(rd, 8'h00);
      end
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 6'h16 + i[5:0], 8'hff);
         bus(1'b0, 6'h16 + i[5:0], 8'h00);
         chk(rd, EXP_EN[i]);
         bus(1'b1, 6'h16 + i[5:0], 8'h00);
      end
      bus(1'b1, 6'h15, 8'hff);
      bus(1'b0, 6'h15, 8'h00);
      chk(rd, 8'h00);
      lvl1 <= '1;
      lvl2 <= '1;
      cyc(2);
      bus(1'b0, 6'h10, 8'h00);
      chk(rd, 8'hbe);
      bus(1'b1, 6'h11, 8'hff);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h13);
      gate(6'h16, 8'h02, 1'b0);
      gate(6'h16, 8'h00, 1'b1);
      gate(6'h17, 8'h01, 1'b0);
      gate(6'h17, 8'h00, 1'b1);
      lvl1 <= '0;
      lvl2 <= '0;
      cyc(2);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h00);
      ev <= '1;
      @(posedge clk);
      ev <= '0;
      cyc(2);
      bus(1'b0, 6'h12, 8'h00);
      chk(rd, 8'hf7);
      bus(1'b0, 6'h13, 8'h00);
      chk(rd, 8'hff);
      bus(1'b0, 6'h14, 8'h00);
      chk(rd, 8'hcf);
      bus(1'b1, 6'h12, 8'h00);
      bus(1'b0, 6'h12, 8'h00);
      chk(rd, 8'hf7);
      bus(1'b1, 6'h12, 8'h01);
      bus(1'b0, 6'h12, 8'h00);
      chk(rd, 8'hf6);
      bus(1'b1, 6'h13, 8'h80);
      bus(1'b0, 6'h13, 8'h00);
      chk(rd, 8'h7f);
      chk({7'h0, grp_n}, 8'h01);
      gate(6'h18, 8'h02, 1'b0);
      chk({7'h0, pin_n}, 8'h01);
      chk({6'h0, route}, 8'h00);
      bus(1'b1, 6'h17, 8'he0);
      cyc(3);
      chk({7'h0, pin_n}, 8'h00);
      chk({6'h0, route}, 8'h03);
      chk(pin_falls[7:0], 8'h01);
      chk(serial_rises[7:0], 8'h01);
      gate(6'h12, 8'h02, 1'b1);
      chk({7'h0, pin_n}, 8'h01);
      // Event pulse sits in the data phase, so it meets the clearing write
      fork
         bus(1'b1, 6'h12, 8'hff);
         begin
            @(posedge clk);
            ev.grp3 <= 8'h01;
            @(posedge clk);
            ev <= '0;
         end
      join
      bus(1'b0, 6'h12, 8'h00);
      chk(rd, 8'h01);
      gate(6'h19, 8'h40, 1'b0);
      gate(6'h19, 8'h00, 1'b1);
      gate(6'h1a, 8'h80, 1'b0);
      gate(6'h1a, 8'h30, 1'b1);
      ir_a <= 1'b1;
      cyc(8);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h04);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h00);
      ir_b <= 1'b1;
      cyc(8);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h00);
      ir_sel <= 1'b1;
      cyc(8);
      ir_b <= 1'b0;
      cyc(8);
      bus(1'b0, 6'h11, 8'h00);
      chk(rd, 8'h04);
      tally_and_finish();
   end
endmodule : ssea_aggregator_bench

// >>> tb/ssea_host_model.sv
// Host-side management logic: receives the pin, serial and wake routes.
// Counts pin assertions so the bench can see each one arrive once.
`timescale 1ns/1ns
module ssea_host_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic mgmt_irq_pin_n,
   input wire ssea_pkg::ssea_route_t group_route,
   output int pin_falls,
   output int serial_rises
);
   import ssea_pkg::*;
   logic pin_n_r;
   logic serial_r;
   // Reset parks the edge history at the idle levels so release gives no false edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pin_n_r <= 1'b1;
         serial_r <= 1'b0;
         pin_falls <= 0;
         serial_rises <= 0;
      end else begin
         pin_n_r <= mgmt_irq_pin_n;
         serial_r <= group_route.serial_irq_req;
         if (pin_n_r && !mgmt_irq_pin_n) begin
            pin_falls <= pin_falls + 1;
         end
         if (!serial_r && group_route.serial_irq_req) begin
            serial_rises <= serial_rises + 1;
         end
      end
   end
endmodule : ssea_host_model
